/* src/i2c_ctl_pkg.sv */
// Package: register map, field layout and shared types of the two-wire control block
package i2c_ctl_pkg;

	// Register indices (printed offsets are not word aligned)
	localparam logic [19:0] IDX_NOISE_FILTER_CLOCK  = 20'h8a008;
	localparam logic [19:0] IDX_MODE_DELAY          = 20'h8a009;
	localparam logic [19:0] IDX_ACK_CONTROL         = 20'h8a00a;
	localparam logic [19:0] IDX_CONDITION_CONTROL   = 20'h8a00b;
	// Own control/status registers (index form as well)
	localparam logic [19:0] IDX_SERIAL_CONTROL      = 20'h8a00c;
	localparam logic [19:0] IDX_PIN_STATUS          = 20'h8a00d;

	// Field positions
	localparam int FCS_LSB    = 0;
	localparam int MODE_BIT   = 0;
	localparam int DLY_LSB    = 3;
	localparam int INTM_BIT   = 0;
	localparam int CSC_BIT    = 1;
	localparam int ACKT_BIT   = 5;
	localparam int STA_BIT    = 0;
	localparam int RSTA_BIT   = 1;
	localparam int STP_BIT    = 2;
	localparam int STIF_BIT   = 3;
	localparam int SDAS_LSB   = 4;
	localparam int SCLS_LSB   = 6;
	localparam int TX_BIT     = 0;
	localparam int RX_BIT     = 1;
	localparam int TX_END_IRQ_EN_BIT   = 2;
	localparam int FEN_BIT    = 3;
	localparam int CIF_BIT    = 4;
	localparam int CKS_LSB    = 5;

	// Reset values
	localparam logic [2:0] FCS_RST  = 3'h0;
	localparam logic [4:0] DLY_RST  = 5'h00;
	localparam logic       ACKT_RST = 1'b1;
	localparam logic [1:0] PSEL_RST = 2'h3;

	// Pin output select codes
	localparam logic [1:0] PIN_SERIAL = 2'h0;
	localparam logic [1:0] PIN_COND   = 2'h1;
	localparam logic [1:0] PIN_LOW    = 2'h2;
	localparam logic [1:0] PIN_HIZ    = 2'h3;

	// Timing: bus condition phase length, in baud-generator ticks, less one
	localparam logic [7:0] COND_PHASE_TICKS = 8'h04;
	localparam logic [7:0] BRG_DIV_RST      = 8'h00;

	typedef enum logic [1:0] {
		MODE_ASYNC = 2'b00,
		MODE_TWI   = 2'b01,
		MODE_CARD  = 2'b10,
		MODE_BAD   = 2'b11
	} op_mode_t;

	// One open-drain pin as two signals
	typedef struct packed {
		logic o;
		logic oe;
	} od_pin_t;

	// Serial engine hooks
	typedef struct packed {
		logic data;
		logic clk;
		logic ack_slot_rise;
	} engine_t;

	function automatic logic [7:0] addr_to_idx_lo(input logic [21:0] a);
		return a[9:2];
	endfunction

endpackage

/* src/i2c_prescale.sv */
// Baud tick divider with prescaler and filter clock dividers
`timescale 1ns/1ps
module i2c_prescale #(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Settings
	input  wire logic [1:0]       prescale_sel,
	input  wire logic [DIV_W-1:0] brg_div,
	input  wire logic [2:0]       filter_clock_sel,
	// Enables
	output logic                  brg_tick,
	output logic                  filt_tick
);
	typedef struct packed {
		logic [6:0]       pre;
		logic [DIV_W-1:0] brg;
		logic [2:0]       flt;
		logic             brg_tick;
		logic             filt_tick;
	} st_t;

	st_t st_ff;
	st_t nxt_st;

	function automatic logic [6:0] pre_mask(input logic [1:0] s);
		unique case (s)
			2'h0: return 7'h00;
			2'h1: return 7'h03;
			2'h2: return 7'h0f;
			2'h3: return 7'h3f;
		endcase
	endfunction

	always_comb begin
		logic pre_tick;
		pre_tick = 1'b0;
		nxt_st = st_ff;
		nxt_st.brg_tick = 1'b0;
		nxt_st.filt_tick = 1'b0;
		// Prescaler divides pclk by 1, 4, 16 or 64
		pre_tick = (st_ff.pre & pre_mask(prescale_sel)) ==
			pre_mask(prescale_sel);
		nxt_st.pre = st_ff.pre + 7'h01;
		if (pre_tick) begin
			// Filter sampling clock: /1, /2, /4, /8 of the prescaled clock
			nxt_st.flt = st_ff.flt + 3'h1;
			unique case (filter_clock_sel)
				3'h1: nxt_st.filt_tick = 1'b1;
				3'h2: nxt_st.filt_tick = st_ff.flt[0];
				3'h3: nxt_st.filt_tick = &st_ff.flt[1:0];
				3'h4: nxt_st.filt_tick = &st_ff.flt;
				default: nxt_st.filt_tick = 1'b1;
			endcase
			// Baud generator clock derived from the prescaled pclk
			if (st_ff.brg >= brg_div) begin
				nxt_st.brg = '0;
				nxt_st.brg_tick = 1'b1;
			end else begin
				nxt_st.brg = st_ff.brg + {{(DIV_W-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign brg_tick = st_ff.brg_tick;
	assign filt_tick = st_ff.filt_tick;
endmodule

/* src/i2c_noise_filter.sv */
// Synchroniser and three-equal-sample noise filter for one bus input
`timescale 1ns/1ps
module i2c_noise_filter (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic filter_on,
	input  wire logic sample_tick,
	// Pin side
	input  wire logic pin_in,
	// Filtered level
	output logic      level
);
	typedef struct packed {
		logic       s1;
		logic       s2;
		logic [2:0] smp;
		logic       lvl;
	} st_t;

	st_t st_ff;
	st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = pin_in;
		nxt_st.s2 = st_ff.s1;
		if (!filter_on) begin
			nxt_st.lvl = st_ff.s2;
		end else if (sample_tick) begin
			nxt_st.smp = {st_ff.smp[1:0], st_ff.s2};
			// Level changes only after three equal samples
			if (&nxt_st.smp) begin
				nxt_st.lvl = 1'b1;
			end else if (~|nxt_st.smp) begin
				nxt_st.lvl = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{s1: 1'b1, s2: 1'b1, smp: 3'h7, lvl: 1'b1};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level = st_ff.lvl;
endmodule

/* src/serial_i2c_mode_control.sv */
// Two-wire mode control: registers, condition generator, pin drive
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module serial_i2c_mode_control #(
	parameter logic [7:0] BRG_DIV = i2c_ctl_pkg::BRG_DIV_RST
) (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [21:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Bus pins, open drain
	input  wire logic        bus_clock_pin_i,
	output logic             bus_clock_pin_o,
	output logic             bus_clock_pin_oe,
	input  wire logic        bus_data_pin_i,
	output logic             bus_data_pin_o,
	output logic             bus_data_pin_oe,
	// Shift engine side
	input  wire logic        eng_data,
	input  wire logic        eng_clk,
	input  wire logic        eng_ack_slot,
	input  wire logic        eng_tx_irq,
	input  wire logic        eng_rx_irq,
	input  wire logic        eng_ack_irq,
	output logic             bus_clock_level,
	output logic             bus_data_level,
	output logic             baud_tick,
	output logic             scl_stretch,
	// Mode and interrupt outputs
	output logic [1:0]       op_mode,
	output logic             ack_tx_value,
	output logic             ack_rx_flag,
	output logic             two_wire_irq,
	output logic             cond_done_irq
);
	typedef enum logic [2:0] {
		C_IDLE = 3'b000,
		C_REL  = 3'b001,
		C_SCLH = 3'b010,
		C_SDAL = 3'b011,
		C_SDAH = 3'b100,
		C_DONE = 3'b101
	} cond_t;

	typedef struct packed {
		logic [2:0] filter_clock_sel;
		logic       two_wire_mode_sel;
		logic [4:0] data_out_delay;
		logic       irq_source_sel;
		logic       scl_sync_en;
		logic       ack_tx_value;
		logic       start_req;
		logic       repeat_start_req;
		logic       stop_req;
		logic       cond_done_flag;
		logic [1:0] data_pin_out_sel;
		logic [1:0] clock_pin_out_sel;
		logic       tx_on;
		logic       rx_on;
		logic       tx_end_irq_en;
		logic       filter_on;
		logic       card_if_sel;
		logic [1:0] prescale_sel;
		logic       ack_rx_flag;
		cond_t      cond;
		logic [7:0] phase;
		logic       cond_sda;
		logic       cond_scl;
		logic [4:0] dly;
		logic       dly_sda;
		logic       scl_prev;
		logic [31:0] rdata;
	} st_t;

	st_t st_ff;
	st_t nxt_st;

	logic brg_tick;
	logic filt_tick;
	logic scl_lvl;
	logic sda_lvl;

	i2c_prescale #(
		.DIV_W(8)
	) u_pre (
		.pclk             (pclk),
		.presetn          (presetn),
		.prescale_sel     (st_ff.prescale_sel),
		.brg_div          (BRG_DIV),
		.filter_clock_sel (st_ff.filter_clock_sel),
		.brg_tick         (brg_tick),
		.filt_tick        (filt_tick)
	);

	i2c_noise_filter u_fscl (
		.pclk        (pclk),
		.presetn     (presetn),
		.filter_on   (st_ff.filter_on & st_ff.two_wire_mode_sel),
		.sample_tick (filt_tick),
		.pin_in      (bus_clock_pin_i),
		.level       (scl_lvl)
	);

	i2c_noise_filter u_fsda (
		.pclk        (pclk),
		.presetn     (presetn),
		.filter_on   (st_ff.filter_on & st_ff.two_wire_mode_sel),
		.sample_tick (filt_tick),
		.pin_in      (bus_data_pin_i),
		.level       (sda_lvl)
	);

	function automatic logic is_reg(input logic [21:0] a,
	                                input logic [19:0] idx);
		return a == {idx, 2'b00};
	endfunction

	logic wr;
	logic rd_ok;
	logic idle_cfg;
	assign wr = psel & penable & pwrite & pstrb[0];
	assign idle_cfg = ~st_ff.tx_on & ~st_ff.rx_on;
	assign rd_ok = is_reg(paddr, i2c_ctl_pkg::IDX_NOISE_FILTER_CLOCK)
		| is_reg(paddr, i2c_ctl_pkg::IDX_MODE_DELAY)
		| is_reg(paddr, i2c_ctl_pkg::IDX_ACK_CONTROL)
		| is_reg(paddr, i2c_ctl_pkg::IDX_CONDITION_CONTROL)
		| is_reg(paddr, i2c_ctl_pkg::IDX_SERIAL_CONTROL)
		| is_reg(paddr, i2c_ctl_pkg::IDX_PIN_STATUS);

	always_comb begin
		logic [7:0] w;
		logic       cond_sel;
		logic       any_req;
		logic       done_ev;
		logic       clr_ev;
		logic       scl_fall;
		w = pwdata[7:0];
		cond_sel = 1'b0;
		any_req = 1'b0;
		done_ev = 1'b0;
		clr_ev = 1'b0;
		scl_fall = 1'b0;
		nxt_st = st_ff;
		// Register writes
		if (wr && is_reg(paddr, i2c_ctl_pkg::IDX_NOISE_FILTER_CLOCK) &&
			idle_cfg) begin
			nxt_st.filter_clock_sel = w[i2c_ctl_pkg::FCS_LSB +: 3];
		end
		if (wr && is_reg(paddr, i2c_ctl_pkg::IDX_MODE_DELAY) && idle_cfg) begin
			nxt_st.two_wire_mode_sel = w[i2c_ctl_pkg::MODE_BIT];
			nxt_st.data_out_delay = w[i2c_ctl_pkg::DLY_LSB +: 5];
		end
		if (wr && is_reg(paddr, i2c_ctl_pkg::IDX_ACK_CONTROL)) begin
			if (idle_cfg) begin
				nxt_st.irq_source_sel = w[i2c_ctl_pkg::INTM_BIT];
				nxt_st.scl_sync_en = w[i2c_ctl_pkg::CSC_BIT];
			end
			nxt_st.ack_tx_value = w[i2c_ctl_pkg::ACKT_BIT];
		end
		if (wr && is_reg(paddr, i2c_ctl_pkg::IDX_CONDITION_CONTROL)) begin
			// Writing 0 to an active request aborts it
			nxt_st.start_req = w[i2c_ctl_pkg::STA_BIT];
			nxt_st.repeat_start_req = w[i2c_ctl_pkg::RSTA_BIT];
			nxt_st.stop_req = w[i2c_ctl_pkg::STP_BIT];
			nxt_st.data_pin_out_sel = w[i2c_ctl_pkg::SDAS_LSB +: 2];
			nxt_st.clock_pin_out_sel = w[i2c_ctl_pkg::SCLS_LSB +: 2];
			if (!w[i2c_ctl_pkg::STIF_BIT]) begin
				clr_ev = 1'b1;
			end
		end
		if (wr && is_reg(paddr, i2c_ctl_pkg::IDX_SERIAL_CONTROL)) begin
			nxt_st.tx_on = w[i2c_ctl_pkg::TX_BIT];
			nxt_st.rx_on = w[i2c_ctl_pkg::RX_BIT];
			nxt_st.tx_end_irq_en = w[i2c_ctl_pkg::TX_END_IRQ_EN_BIT];
			if (!w[i2c_ctl_pkg::TX_BIT]) begin
				clr_ev = 1'b1;
			end
			if (idle_cfg) begin
				nxt_st.filter_on = w[i2c_ctl_pkg::FEN_BIT];
				nxt_st.card_if_sel = w[i2c_ctl_pkg::CIF_BIT];
				nxt_st.prescale_sel = w[i2c_ctl_pkg::CKS_LSB +: 2];
			end
		end
		if (wr && is_reg(paddr, i2c_ctl_pkg::IDX_MODE_DELAY) &&
			!w[i2c_ctl_pkg::MODE_BIT]) begin
			clr_ev = 1'b1;
		end

		// Condition generator
		cond_sel = st_ff.data_pin_out_sel == i2c_ctl_pkg::PIN_COND &&
			st_ff.clock_pin_out_sel == i2c_ctl_pkg::PIN_COND;
		any_req = st_ff.start_req | st_ff.repeat_start_req | st_ff.stop_req;
		if (!any_req || !cond_sel) begin
			nxt_st.cond = C_IDLE;
			nxt_st.phase = '0;
		end else if (brg_tick) begin
			if (st_ff.phase != i2c_ctl_pkg::COND_PHASE_TICKS) begin
				nxt_st.phase = st_ff.phase + 8'h01;
			end else begin
				nxt_st.phase = '0;
				unique case (st_ff.cond)
					C_IDLE: begin
						if (st_ff.start_req) begin
							nxt_st.cond = C_SDAL;
						end else if (st_ff.repeat_start_req) begin
							nxt_st.cond = C_REL;
						end else begin
							nxt_st.cond = C_SDAL;
						end
						nxt_st.cond_sda = st_ff.start_req;
						nxt_st.cond_scl = st_ff.start_req;
					end
					C_REL: begin
						nxt_st.cond_sda = 1'b1;
						nxt_st.cond = C_SCLH;
					end
					C_SCLH: begin
						nxt_st.cond_scl = 1'b1;
						if (!st_ff.scl_sync_en || scl_lvl) begin
							nxt_st.cond = C_SDAL;
						end
					end
					C_SDAL: begin
						if (st_ff.stop_req) begin
							nxt_st.cond_sda = 1'b0;
							nxt_st.cond = C_SCLH;
							nxt_st.cond_scl = 1'b0;
							nxt_st.cond = C_SDAH;
						end else begin
							nxt_st.cond_sda = 1'b0;
							nxt_st.cond = C_DONE;
						end
					end
					C_SDAH: begin
						if (!st_ff.cond_scl) begin
							nxt_st.cond_scl = 1'b1;
						end else if (!st_ff.scl_sync_en || scl_lvl) begin
							nxt_st.cond_sda = 1'b1;
							nxt_st.cond = C_DONE;
						end
					end
					C_DONE: begin
						done_ev = 1'b1;
						nxt_st.cond = C_IDLE;
						nxt_st.start_req = 1'b0;
						nxt_st.repeat_start_req = 1'b0;
						nxt_st.stop_req = 1'b0;
					end
					default: nxt_st.cond = C_IDLE;
				endcase
			end
		end
		// Clear takes precedence over the completion set
		if (clr_ev) begin
			nxt_st.cond_done_flag = 1'b0;
		end else if (done_ev) begin
			nxt_st.cond_done_flag = 1'b1;
		end

		// Data output delay after clock falling edge
		nxt_st.scl_prev = eng_clk;
		scl_fall = st_ff.scl_prev & ~eng_clk;
		if (scl_fall) begin
			nxt_st.dly = st_ff.data_out_delay;
			if (st_ff.data_out_delay == 5'h00) begin
				nxt_st.dly_sda = eng_data;
			end
		end else if (st_ff.dly != 5'h00 && brg_tick) begin
			nxt_st.dly = st_ff.dly - 5'h01;
			if (st_ff.dly == 5'h01) begin
				nxt_st.dly_sda = eng_data;
			end
		end else if (st_ff.dly == 5'h00 && eng_clk) begin
			nxt_st.dly_sda = eng_data;
		end

		// Received ack sampled while the bus clock is high in the ack slot
		if (eng_ack_slot && scl_lvl && !st_ff.ack_rx_flag && sda_lvl) begin
			nxt_st.ack_rx_flag = 1'b1;
		end else if (eng_ack_slot && scl_lvl && !sda_lvl) begin
			nxt_st.ack_rx_flag = 1'b0;
		end

		// Read data, reserved bits zero
		nxt_st.rdata = '0;
		if (is_reg(paddr, i2c_ctl_pkg::IDX_NOISE_FILTER_CLOCK)) begin
			nxt_st.rdata[2:0] = st_ff.filter_clock_sel;
		end else if (is_reg(paddr, i2c_ctl_pkg::IDX_MODE_DELAY)) begin
			nxt_st.rdata[7:0] = {st_ff.data_out_delay, 2'b00,
				st_ff.two_wire_mode_sel};
		end else if (is_reg(paddr, i2c_ctl_pkg::IDX_ACK_CONTROL)) begin
			nxt_st.rdata[7:0] = {2'b00, st_ff.ack_tx_value, 3'b000,
				st_ff.scl_sync_en, st_ff.irq_source_sel};
		end else if (is_reg(paddr, i2c_ctl_pkg::IDX_CONDITION_CONTROL)) begin
			nxt_st.rdata[7:0] = {st_ff.clock_pin_out_sel,
				st_ff.data_pin_out_sel, st_ff.cond_done_flag,
				st_ff.stop_req, st_ff.repeat_start_req, st_ff.start_req};
		end else if (is_reg(paddr, i2c_ctl_pkg::IDX_SERIAL_CONTROL)) begin
			nxt_st.rdata[6:0] = {st_ff.prescale_sel, st_ff.card_if_sel,
				st_ff.filter_on, st_ff.tx_end_irq_en, st_ff.rx_on,
				st_ff.tx_on};
		end else if (is_reg(paddr, i2c_ctl_pkg::IDX_PIN_STATUS)) begin
			nxt_st.rdata[2:0] = {st_ff.ack_rx_flag, sda_lvl, scl_lvl};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.ack_tx_value <= i2c_ctl_pkg::ACKT_RST;
			st_ff.data_pin_out_sel <= i2c_ctl_pkg::PSEL_RST;
			st_ff.clock_pin_out_sel <= i2c_ctl_pkg::PSEL_RST;
			st_ff.filter_clock_sel <= i2c_ctl_pkg::FCS_RST;
			st_ff.data_out_delay <= i2c_ctl_pkg::DLY_RST;
			st_ff.cond_sda <= 1'b1;
			st_ff.cond_scl <= 1'b1;
			st_ff.dly_sda <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Pin drive select open-drain
	function automatic logic pin_level(input logic [1:0] s,
	                                   input logic serial,
	                                   input logic cond);
		unique case (s)
			i2c_ctl_pkg::PIN_SERIAL: return serial;
			i2c_ctl_pkg::PIN_COND:   return cond;
			i2c_ctl_pkg::PIN_LOW:    return 1'b0;
			i2c_ctl_pkg::PIN_HIZ:    return 1'b1;
		endcase
	endfunction

	assign bus_clock_pin_o = 1'b0;
	assign bus_data_pin_o = 1'b0;
	assign bus_clock_pin_oe = ~pin_level(st_ff.clock_pin_out_sel, eng_clk,
		st_ff.cond_scl);
	assign bus_data_pin_oe = ~pin_level(st_ff.data_pin_out_sel,
		st_ff.dly_sda, st_ff.cond_sda);

	// Clock stretch: engine waits while bus clock is held low
	assign scl_stretch = st_ff.scl_sync_en & eng_clk & ~scl_lvl;
	assign bus_clock_level = scl_lvl;
	assign bus_data_level = sda_lvl;
	assign baud_tick = brg_tick;
	assign op_mode = {st_ff.card_if_sel, st_ff.two_wire_mode_sel};
	assign ack_tx_value = st_ff.ack_tx_value;
	assign ack_rx_flag = st_ff.ack_rx_flag;
	assign two_wire_irq = st_ff.irq_source_sel ? (eng_tx_irq | eng_rx_irq)
		: eng_ack_irq;
	assign cond_done_irq = st_ff.cond_done_flag & st_ff.tx_end_irq_en;

	// APB answers in the access cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~rd_ok;
	assign prdata = st_ff.rdata;
endmodule

/* testbench/i2c_ctl_props.sv */
// Port-level checker for the two-wire mode control block
`timescale 1ns/1ps
module i2c_ctl_props (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Pins and mode
	input wire logic        bus_clock_pin_o,
	input wire logic        bus_data_pin_o,
	input wire logic [1:0]  op_mode,
	input wire logic        ack_tx_value,
	input wire logic        cond_done_irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Any cycle that is not a completed APB write
	sequence idle_bus;
		!(psel && penable && pwrite);
	endsequence

	a_err_phase: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access phase");
	a_err_data: assert property (pslverr |-> prdata == 32'h0)
		else $error("unmapped read returned data");
	a_clk_open: assert property (bus_clock_pin_o == 1'b0)
		else $error("clock pin driven high");
	a_data_open: assert property (bus_data_pin_o == 1'b0)
		else $error("data pin driven high");
	a_mode_hold: assert property (idle_bus |=> $stable(op_mode))
		else $error("mode changed without a write");
	a_ack_cause: assert property ($changed(ack_tx_value) |->
		$past(psel && penable && pwrite))
		else $error("ack value changed without a write");
	a_irq_fall: assert property ($fell(cond_done_irq) |->
		$past(psel && penable && pwrite))
		else $error("done interrupt dropped without a write");
	a_irq_hold: assert property (cond_done_irq && !pwrite |=>
		cond_done_irq)
		else $error("done interrupt dropped on its own");
endmodule

/* testbench/i2c_bus_peer.sv */
// Other bus devices: pull-ups plus a device that can hold either line
`timescale 1ns/1ps
module i2c_bus_peer (
	// Design drive
	input  wire logic clk_oe,
	input  wire logic data_oe,
	// Peer holds
	input  wire logic hold_clk,
	input  wire logic hold_data,
	// Resolved lines
	output logic      clk_line,
	output logic      data_line
);
	// Wired-AND with pull-up; a held clock is a stretch
	assign clk_line  = !(clk_oe || hold_clk);
	assign data_line = !(data_oe || hold_data);
endmodule

/* testbench/tb.sv */
// Self-checking bench for the two-wire mode control block
`timescale 1ns/1ps
module tb;
	localparam logic [19:0] NFC = i2c_ctl_pkg::IDX_NOISE_FILTER_CLOCK;
	localparam logic [19:0] MD  = i2c_ctl_pkg::IDX_MODE_DELAY;
	localparam logic [19:0] AK  = i2c_ctl_pkg::IDX_ACK_CONTROL;
	localparam logic [19:0] CC  = i2c_ctl_pkg::IDX_CONDITION_CONTROL;
	localparam logic [19:0] SC  = i2c_ctl_pkg::IDX_SERIAL_CONTROL;
	localparam logic [19:0] ST  = i2c_ctl_pkg::IDX_PIN_STATUS;
	typedef struct packed {
		logic [19:0] i;
		logic [7:0]  d;
		logic [7:0]  e;
	} row_t;
	row_t rows [8] = '{'{NFC, 8'hff, 8'h07}, '{NFC, 8'h01, 8'h01},
		'{NFC, 8'h02, 8'h02}, '{NFC, 8'h03, 8'h03}, '{NFC, 8'h04, 8'h04},
		'{MD, 8'hff, 8'hf9}, '{AK, 8'hff, 8'h23}, '{CC, 8'hf0, 8'hf0}};
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [21:0] paddr = 22'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        clk_line, clk_o, clk_oe, dat_line, dat_o, dat_oe;
	logic        hold_clk = 1'b0;
	logic        hold_data = 1'b0;
	logic        eng_clk = 1'b0;
	logic        tx_irq = 1'b0;
	logic        rx_irq = 1'b0;
	logic        ack_irq = 1'b0;
	logic        clk_lvl, dat_lvl, btick, stretch, ackt, ackr, twi_irq, dirq;
	logic [1:0]  op_mode;
	logic [31:0] rd;
	logic        er;
	int          err_total = 0;
	int          checks = 0;
	int          cyc = 0;

	always #2.5 pclk = ~pclk;

	serial_i2c_mode_control #(.BRG_DIV(8'h00)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_clock_pin_i(clk_line), .bus_clock_pin_o(clk_o),
		.bus_clock_pin_oe(clk_oe), .bus_data_pin_i(dat_line),
		.bus_data_pin_o(dat_o), .bus_data_pin_oe(dat_oe),
		.eng_data(1'b0), .eng_clk(eng_clk), .eng_ack_slot(1'b0),
		.eng_tx_irq(tx_irq), .eng_rx_irq(rx_irq), .eng_ack_irq(ack_irq),
		.bus_clock_level(clk_lvl), .bus_data_level(dat_lvl),
		.baud_tick(btick), .scl_stretch(stretch), .op_mode(op_mode),
		.ack_tx_value(ackt), .ack_rx_flag(ackr), .two_wire_irq(twi_irq),
		.cond_done_irq(dirq));

	i2c_bus_peer peer (.clk_oe(clk_oe), .data_oe(dat_oe),
		.hold_clk(hold_clk), .hold_data(hold_data),
		.clk_line(clk_line), .data_line(dat_line));

	task automatic chk(input logic [31:0] seen, input logic [31:0] ex,
		input string nm);
		checks++;
		if (seen !== ex) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [19:0] i,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdx(input logic [19:0] i, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		chk(rd, {24'h0, e}, "read data");
	endtask

	// Poll the condition register until the done flag shows
	task automatic wait_done;
		int n;
		n = 0;
		apb(1'b0, CC, 8'h00);
		while (rd[3] !== 1'b1 && n < 1000) begin
			apb(1'b0, CC, 8'h00);
			n++;
		end
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			close_out();
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[k]) begin
			apb(1'b1, rows[k].i, rows[k].d);
			rdx(rows[k].i, rows[k].e);
		end
		chk(op_mode, 2'b01, "op_mode");
		chk(btick, 1'b1, "baud_tick");
		$display("register table done");
		apb(1'b1, 20'h8a00f, 8'hff);
		chk(er, 1'b1, "pslverr");
		rdx(20'h8a00f, 8'h00);
		apb(1'b1, SC, 8'h01);
		apb(1'b1, NFC, 8'h01);
		apb(1'b1, MD, 8'h09);
		rdx(NFC, 8'h04);
		rdx(MD, 8'hf9);
		apb(1'b1, SC, 8'h00);
		$display("write lock done");
		apb(1'b1, MD, 8'h09);
		tx_irq <= 1'b1;
		apb(1'b1, AK, 8'h23);
		@(posedge pclk);
		chk(twi_irq, 1'b1, "two_wire_irq");
		apb(1'b1, AK, 8'h22);
		@(posedge pclk);
		chk(twi_irq, 1'b0, "two_wire_irq");
		ack_irq <= 1'b1;
		@(posedge pclk);
		chk(twi_irq, 1'b1, "two_wire_irq");
		rdx(AK, 8'h22);
		apb(1'b1, AK, 8'h02);
		rdx(AK, 8'h02);
		chk(ackt, 1'b0, "ack_tx_value");
		tx_irq <= 1'b0;
		ack_irq <= 1'b0;
		$display("interrupt source done");
		apb(1'b1, SC, 8'h05);
		rdx(ST, 8'h03);
		apb(1'b1, CC, 8'h51);
		wait_done();
		chk(rd, 32'h58, "start status");
		chk(dirq, 1'b1, "cond_done_irq");
		chk({clk_oe, dat_oe}, 2'b01, "start pins");
		apb(1'b1, CC, 8'h50);
		rdx(CC, 8'h50);
		chk(dirq, 1'b0, "cond_done_irq");
		apb(1'b1, CC, 8'ha0);
		// Pin levels reach the status register through the synchroniser
		repeat (3) @(posedge pclk);
		rdx(ST, 8'h00);
		chk({clk_oe, dat_oe}, 2'b11, "low pins");
		apb(1'b1, CC, 8'h54);
		wait_done();
		chk(rd, 32'h58, "stop status");
		chk({clk_oe, dat_oe}, 2'b00, "stop pins");
		apb(1'b1, SC, 8'h04);
		rdx(CC, 8'h50);
		$display("conditions done");
		apb(1'b1, SC, 8'h05);
		apb(1'b1, CC, 8'h51);
		apb(1'b1, CC, 8'h50);
		repeat (100) apb(1'b0, CC, 8'h00);
		chk(rd, 32'h50, "abort status");
		hold_clk <= 1'b1;
		eng_clk <= 1'b1;
		apb(1'b0, ST, 8'h00);
		rdx(ST, 8'h02);
		chk(stretch, 1'b1, "scl_stretch");
		chk({clk_lvl, dat_lvl}, 2'b01, "line levels");
		hold_clk <= 1'b0;
		hold_data <= 1'b1;
		eng_clk <= 1'b0;
		apb(1'b0, ST, 8'h00);
		rdx(ST, 8'h01);
		chk(stretch, 1'b0, "scl_stretch");
		hold_data <= 1'b0;
		$display("abort and stretch done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdx(NFC, 8'h00);
		rdx(MD, 8'h00);
		rdx(AK, 8'h20);
		rdx(CC, 8'hf0);
		chk({clk_oe, dat_oe}, 2'b00, "reset pins");
		$display("reset values done");
		close_out();
	end
endmodule

bind serial_i2c_mode_control i2c_ctl_props u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
	.bus_clock_pin_o(bus_clock_pin_o), .bus_data_pin_o(bus_data_pin_o),
	.op_mode(op_mode), .ack_tx_value(ack_tx_value),
	.cond_done_irq(cond_done_irq));
